// ### erlc_pkg.sv
// Constants and types shared by the error-response and limit control block
`default_nettype none
package erlc_pkg;
  // ****************************************
  // Host commands
  // ****************************************
  typedef enum logic [3:0] {
    CMD_CURR_CFG  = 4'h0,
    CMD_VOLT_CFG  = 4'h1,
    CMD_OFF_SEL   = 4'h2,
    CMD_OFF_VLIM  = 4'h3,
    CMD_OFF_ILIM  = 4'h4,
    CMD_ON_VLIM   = 4'h5,
    CMD_ON_ILIM   = 4'h6,
    CMD_WINDOW    = 4'h7,
    CMD_OPTIONS   = 4'h8,
    CMD_SAVE_SHUT = 4'h9,
    CMD_SAVE_INTF = 4'hA,
    CMD_SEC_CLEAR = 4'hB,
    CMD_RESET     = 4'hC,
    CMD_DEV_CLEAR = 4'hD,
    CMD_OUT_ON    = 4'hE,
    CMD_OUT_OFF   = 4'hF
  } erlc_cmd_type;

  // ****************************************
  // Field positions
  // ****************************************
  localparam logic [2:0] CFG_FIXED_LIM = 3'h7;
  localparam logic [2:0] CFG_PROT_EN   = 3'h6;
  localparam logic [2:0] CFG_ESR_EN    = 3'h5;
  localparam logic [2:0] CFG_ESE_INIT  = 3'h4;
  localparam logic [2:0] CFG_ERR_MSG   = 3'h3;
  localparam logic [2:0] CFG_PROT_OFF  = 3'h2;
  localparam logic [2:0] CFG_MEAS_MSG  = 3'h1;
  localparam logic [2:0] CFG_MEAS_ACT  = 3'h0;
  localparam logic [1:0] SEL_VMAX      = 2'h0;
  localparam logic [1:0] SEL_IMAX      = 2'h1;
  localparam logic [1:0] SEL_VUSER     = 2'h2;
  localparam logic [1:0] SEL_IUSER     = 2'h3;
  localparam logic [1:0] OPT_LF        = 2'h0;
  localparam logic [1:0] OPT_DC        = 2'h1;
  localparam logic [1:0] OPT_RO        = 2'h2;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] CFG_RST       = 8'h00;
  localparam logic [3:0] OFF_SEL_RST   = 4'h0;
  localparam logic [7:0] LIMIT_VAL_RST = 8'h00;
  localparam logic [7:0] WINDOW_RST    = 8'h20;
  localparam logic [2:0] OPTIONS_RST   = 3'h0;
  localparam logic [7:0] LIMIT_ZERO    = 8'h00;
  localparam logic [7:0] LIMIT_MAX     = 8'hFF;
  localparam logic [7:0] ESE_RST       = 8'h00;
  localparam logic [7:0] ESE_CPE_VAL   = 8'h48;
  localparam logic [7:0] ESE_BASE_VAL  = 8'h08;
  localparam logic [9:0] ERR_NONE      = 10'h000;
  localparam logic [9:0] ERR_DEVICE    = 10'h12C;
  localparam logic [9:0] ERR_CURR_PROT = 10'h12F;
  localparam logic [9:0] ERR_VOLT_PROT = 10'h130;
endpackage : erlc_pkg
`default_nettype wire

// ### erlc_limit_mux.sv
// Limit channel level selection for one limit DAC
`default_nettype none
module erlc_limit_mux (
  // Output state
  input  wire logic       output_on,
  // Off-state selection
  input  wire logic       force_max,
  input  wire logic       use_user,
  input  wire logic [7:0] off_value,
  // On-state selection
  input  wire logic       fixed_on,
  input  wire logic [7:0] on_value,
  // Selected level
  output logic      [7:0] level
);
  // Maximum is checked before the user value so a conflicting select stays safe-high
  always_comb begin
    if (output_on) begin
      level = fixed_on ? on_value : erlc_pkg::LIMIT_MAX;
    end else if (force_max) begin
      level = erlc_pkg::LIMIT_MAX;
    end else if (use_user) begin
      level = off_value;
    end else begin
      level = erlc_pkg::LIMIT_ZERO;
    end
  end
endmodule : erlc_limit_mux
`default_nettype wire

// ### erlc_core.sv
// Error-response and output-limit control for one supply channel
`default_nettype none
module erlc_core (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  // Host command port
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_READ,
  input  wire logic [3:0]  CMD_CODE,
  input  wire logic [7:0]  CMD_DATA,
  output logic             RESP_VALID,
  output logic      [7:0]  RESP_DATA,
  // Power and bus events
  input  wire logic        POWER_UP,
  input  wire logic        READ_EMPTY,
  output logic             LF_SEND,
  output logic             STATUS_CLEAR,
  output logic             RESET_LEVELS,
  // Measurement and protection events
  input  wire logic        MODE_CURRENT,
  input  wire logic        MEAS_VALID,
  input  wire logic [15:0] MEAS_MAIN,
  input  wire logic [15:0] SET_MAIN,
  input  wire logic        CURR_PROT_EVT,
  input  wire logic        VOLT_PROT_EVT,
  input  wire logic        CURR_MEAS_ERR,
  input  wire logic        VOLT_MEAS_ERR,
  output logic             QUES_OUT_OF_TOL,
  // Output control
  output logic             OUTPUT_ON,
  output logic             UNIT_SHUTDOWN,
  output logic      [7:0]  VLIM_DAC,
  output logic      [7:0]  ILIM_DAC,
  // Error and event status
  output logic             ERR_VALID,
  output logic      [9:0]  ERR_CODE,
  output logic             CPE_EVENT,
  output logic             ESE_LOAD,
  output logic      [7:0]  ESE_INIT
);
  // ****************************************
  // Helper functions
  // ****************************************
  // Write command decode
  function automatic logic cmd_hit(input logic valid, input logic rd,
                                   input logic [3:0] code, input erlc_pkg::erlc_cmd_type c);
    cmd_hit = valid && !rd && (code == c);
  endfunction : cmd_hit

  // Event enable preset from a current config byte
  function automatic logic [7:0] ese_for(input logic [7:0] cfg);
    if (!cfg[erlc_pkg::CFG_ESE_INIT]) begin
      ese_for = erlc_pkg::ESE_RST;
    end else if (cfg[erlc_pkg::CFG_ESR_EN]) begin
      ese_for = erlc_pkg::ESE_CPE_VAL;
    end else begin
      ese_for = erlc_pkg::ESE_BASE_VAL;
    end
  endfunction : ese_for

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  curr_cfg;
  logic [7:0]  volt_cfg;
  logic [3:0]  off_sel;
  logic [7:0]  off_vlim;
  logic [7:0]  off_ilim;
  logic [7:0]  on_vlim;
  logic [7:0]  on_ilim;
  logic [7:0]  window;
  logic [2:0]  options;
  logic [7:0]  sv_curr_cfg;
  logic [7:0]  sv_volt_cfg;
  logic [3:0]  sv_off_sel;
  logic [7:0]  sv_off_vlim;
  logic [7:0]  sv_off_ilim;
  logic [7:0]  sv_on_vlim;
  logic [7:0]  sv_on_ilim;
  logic [7:0]  sv_window;
  logic [2:0]  sv_options;
  logic [7:0]  next_vlim;
  logic [7:0]  next_ilim;
  logic [15:0] meas_diff;

  // ****************************************
  // Command decode and event terms
  // ****************************************
  logic sec_clear;
  logic dev_clear;
  logic do_reset;
  logic out_on_cmd;
  logic out_off_cmd;
  logic cur_prot;
  logic volt_prot;
  logic cmeas;
  logic vmeas;
  logic trip_off;

  // Decoded strobes
  assign sec_clear   = cmd_hit(CMD_VALID, CMD_READ, CMD_CODE, erlc_pkg::CMD_SEC_CLEAR);
  assign dev_clear   = cmd_hit(CMD_VALID, CMD_READ, CMD_CODE, erlc_pkg::CMD_DEV_CLEAR);
  assign out_on_cmd  = cmd_hit(CMD_VALID, CMD_READ, CMD_CODE, erlc_pkg::CMD_OUT_ON);
  assign out_off_cmd = cmd_hit(CMD_VALID, CMD_READ, CMD_CODE, erlc_pkg::CMD_OUT_OFF);
  assign do_reset    = cmd_hit(CMD_VALID, CMD_READ, CMD_CODE, erlc_pkg::CMD_RESET)
                       || (dev_clear && options[erlc_pkg::OPT_DC]);

  // Protection terms; protect logic is dead unless its enable bit is set
  assign cur_prot  = CURR_PROT_EVT && curr_cfg[erlc_pkg::CFG_PROT_EN];
  assign volt_prot = VOLT_PROT_EVT && volt_cfg[erlc_pkg::CFG_PROT_EN];
  assign cmeas     = CURR_MEAS_ERR && MODE_CURRENT;
  assign vmeas     = VOLT_MEAS_ERR && !MODE_CURRENT && volt_cfg[erlc_pkg::CFG_MEAS_MSG];
  assign trip_off  = (cur_prot && curr_cfg[erlc_pkg::CFG_PROT_OFF])
                     || (volt_prot && volt_cfg[erlc_pkg::CFG_PROT_OFF])
                     || (cmeas && curr_cfg[erlc_pkg::CFG_MEAS_ACT])
                     || (vmeas && volt_cfg[erlc_pkg::CFG_MEAS_ACT]);

  // ****************************************
  // Active configuration
  // ****************************************
  // Working copy; a power cycle reloads it from the saved area
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      curr_cfg <= erlc_pkg::CFG_RST;
      volt_cfg <= erlc_pkg::CFG_RST;
      off_sel  <= erlc_pkg::OFF_SEL_RST;
      off_vlim <= erlc_pkg::LIMIT_VAL_RST;
      off_ilim <= erlc_pkg::LIMIT_VAL_RST;
      on_vlim  <= erlc_pkg::LIMIT_VAL_RST;
      on_ilim  <= erlc_pkg::LIMIT_VAL_RST;
      window   <= erlc_pkg::WINDOW_RST;
      options  <= erlc_pkg::OPTIONS_RST;
    end else if (sec_clear) begin
      curr_cfg <= erlc_pkg::CFG_RST;
      volt_cfg <= erlc_pkg::CFG_RST;
      off_sel  <= erlc_pkg::OFF_SEL_RST;
      off_vlim <= erlc_pkg::LIMIT_VAL_RST;
      off_ilim <= erlc_pkg::LIMIT_VAL_RST;
      on_vlim  <= erlc_pkg::LIMIT_VAL_RST;
      on_ilim  <= erlc_pkg::LIMIT_VAL_RST;
      window   <= erlc_pkg::WINDOW_RST;
      options  <= erlc_pkg::OPTIONS_RST;
    end else if (POWER_UP) begin
      curr_cfg <= sv_curr_cfg;
      volt_cfg <= sv_volt_cfg;
      off_sel  <= sv_off_sel;
      off_vlim <= sv_off_vlim;
      off_ilim <= sv_off_ilim;
      on_vlim  <= sv_on_vlim;
      on_ilim  <= sv_on_ilim;
      window   <= sv_window;
      options  <= sv_options;
    end else if (CMD_VALID && !CMD_READ) begin
      unique case (CMD_CODE)
        erlc_pkg::CMD_CURR_CFG: curr_cfg <= CMD_DATA;
        erlc_pkg::CMD_VOLT_CFG: volt_cfg <= CMD_DATA;
        erlc_pkg::CMD_OFF_SEL:  off_sel  <= CMD_DATA[3:0];
        erlc_pkg::CMD_OFF_VLIM: off_vlim <= CMD_DATA;
        erlc_pkg::CMD_OFF_ILIM: off_ilim <= CMD_DATA;
        erlc_pkg::CMD_ON_VLIM:  on_vlim  <= CMD_DATA;
        erlc_pkg::CMD_ON_ILIM:  on_ilim  <= CMD_DATA;
        erlc_pkg::CMD_WINDOW:   window   <= CMD_DATA;
        erlc_pkg::CMD_OPTIONS:  options  <= CMD_DATA[2:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Saved power-up area
  // ****************************************
  // Stands in for non-volatile storage; only the save commands and a security clear change it
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sv_curr_cfg <= erlc_pkg::CFG_RST;
      sv_volt_cfg <= erlc_pkg::CFG_RST;
      sv_off_sel  <= erlc_pkg::OFF_SEL_RST;
      sv_off_vlim <= erlc_pkg::LIMIT_VAL_RST;
      sv_off_ilim <= erlc_pkg::LIMIT_VAL_RST;
      sv_on_vlim  <= erlc_pkg::LIMIT_VAL_RST;
      sv_on_ilim  <= erlc_pkg::LIMIT_VAL_RST;
      sv_window   <= erlc_pkg::WINDOW_RST;
      sv_options  <= erlc_pkg::OPTIONS_RST;
    end else if (sec_clear) begin
      sv_curr_cfg <= erlc_pkg::CFG_RST;
      sv_volt_cfg <= erlc_pkg::CFG_RST;
      sv_off_sel  <= erlc_pkg::OFF_SEL_RST;
      sv_off_vlim <= erlc_pkg::LIMIT_VAL_RST;
      sv_off_ilim <= erlc_pkg::LIMIT_VAL_RST;
      sv_on_vlim  <= erlc_pkg::LIMIT_VAL_RST;
      sv_on_ilim  <= erlc_pkg::LIMIT_VAL_RST;
      sv_window   <= erlc_pkg::WINDOW_RST;
      sv_options  <= erlc_pkg::OPTIONS_RST;
    end else if (cmd_hit(CMD_VALID, CMD_READ, CMD_CODE, erlc_pkg::CMD_SAVE_SHUT)) begin
      sv_curr_cfg <= curr_cfg;
      sv_volt_cfg <= volt_cfg;
      sv_off_vlim <= off_vlim;
      sv_off_ilim <= off_ilim;
      sv_on_vlim  <= on_vlim;
      sv_on_ilim  <= on_ilim;
      sv_window   <= window;
    end else if (cmd_hit(CMD_VALID, CMD_READ, CMD_CODE, erlc_pkg::CMD_SAVE_INTF)) begin
      sv_off_sel  <= off_sel;
      sv_options  <= options;
    end
  end

  // ****************************************
  // Output state
  // ****************************************
  // A trip wins over an on command arriving in the same cycle
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      OUTPUT_ON <= 1'b0;
    end else if (sec_clear || POWER_UP || trip_off) begin
      OUTPUT_ON <= 1'b0;
    end else if (do_reset) begin
      OUTPUT_ON <= options[erlc_pkg::OPT_RO];
    end else if (out_on_cmd && !UNIT_SHUTDOWN) begin
      OUTPUT_ON <= 1'b1;
    end else if (out_off_cmd) begin
      OUTPUT_ON <= 1'b0;
    end
  end

  // Shutdown latch; only a power cycle releases it, a new trip wins
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      UNIT_SHUTDOWN <= 1'b0;
    end else if (cmeas && curr_cfg[erlc_pkg::CFG_MEAS_ACT]) begin
      UNIT_SHUTDOWN <= 1'b1;
    end else if (POWER_UP) begin
      UNIT_SHUTDOWN <= 1'b0;
    end
  end

  // ****************************************
  // Limit channels
  // ****************************************
  erlc_limit_mux u_vlim (
    .output_on (OUTPUT_ON),
    .force_max (off_sel[erlc_pkg::SEL_VMAX]),
    .use_user  (off_sel[erlc_pkg::SEL_VUSER]),
    .off_value (off_vlim),
    .fixed_on  (volt_cfg[erlc_pkg::CFG_FIXED_LIM]),
    .on_value  (on_vlim),
    .level     (next_vlim)
  );

  erlc_limit_mux u_ilim (
    .output_on (OUTPUT_ON),
    .force_max (off_sel[erlc_pkg::SEL_IMAX]),
    .use_user  (off_sel[erlc_pkg::SEL_IUSER]),
    .off_value (off_ilim),
    .fixed_on  (curr_cfg[erlc_pkg::CFG_FIXED_LIM]),
    .on_value  (on_ilim),
    .level     (next_ilim)
  );

  // Registered so the DAC never sees a glitch from the select logic
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      VLIM_DAC <= erlc_pkg::LIMIT_ZERO;
      ILIM_DAC <= erlc_pkg::LIMIT_ZERO;
    end else begin
      VLIM_DAC <= next_vlim;
      ILIM_DAC <= next_ilim;
    end
  end

  // ****************************************
  // Errors and event status
  // ****************************************
  // One message per cycle; lower-priority coincident messages are dropped
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ERR_VALID <= 1'b0;
      ERR_CODE  <= erlc_pkg::ERR_NONE;
      CPE_EVENT <= 1'b0;
    end else begin
      CPE_EVENT <= cur_prot && curr_cfg[erlc_pkg::CFG_ESR_EN];
      ERR_VALID <= 1'b1;
      if (cur_prot && curr_cfg[erlc_pkg::CFG_ERR_MSG]) begin
        ERR_CODE <= erlc_pkg::ERR_CURR_PROT;
      end else if (volt_prot && volt_cfg[erlc_pkg::CFG_ERR_MSG]) begin
        ERR_CODE <= erlc_pkg::ERR_VOLT_PROT;
      end else if ((cmeas && curr_cfg[erlc_pkg::CFG_MEAS_MSG]) || vmeas) begin
        ERR_CODE <= erlc_pkg::ERR_DEVICE;
      end else begin
        ERR_VALID <= 1'b0;
        ERR_CODE  <= erlc_pkg::ERR_NONE;
      end
    end
  end

  // Event enable preset at power-up and reset
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ESE_LOAD <= 1'b0;
      ESE_INIT <= erlc_pkg::ESE_RST;
    end else begin
      ESE_LOAD <= POWER_UP || do_reset;
      if (POWER_UP) begin
        ESE_INIT <= ese_for(sv_curr_cfg);
      end else if (do_reset) begin
        ESE_INIT <= ese_for(curr_cfg);
      end
    end
  end

  // ****************************************
  // Bus events
  // ****************************************
  // Pulses toward the message and status logic
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LF_SEND      <= 1'b0;
      STATUS_CLEAR <= 1'b0;
      RESET_LEVELS <= 1'b0;
    end else begin
      LF_SEND      <= READ_EMPTY && options[erlc_pkg::OPT_LF];
      STATUS_CLEAR <= dev_clear;
      RESET_LEVELS <= do_reset;
    end
  end

  // ****************************************
  // Tolerance window
  // ****************************************
  assign meas_diff = (MEAS_MAIN >= SET_MAIN) ? MEAS_MAIN - SET_MAIN : SET_MAIN - MEAS_MAIN;

  // Flag holds until the next measurement
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      QUES_OUT_OF_TOL <= 1'b0;
    end else if (MEAS_VALID) begin
      QUES_OUT_OF_TOL <= meas_diff > {8'h00, window};
    end
  end

  // ****************************************
  // Query answers
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RESP_VALID <= 1'b0;
      RESP_DATA  <= 8'h00;
    end else begin
      RESP_VALID <= CMD_VALID && CMD_READ;
      if (CMD_VALID && CMD_READ) begin
        unique case (CMD_CODE)
          erlc_pkg::CMD_CURR_CFG: RESP_DATA <= curr_cfg;
          erlc_pkg::CMD_VOLT_CFG: RESP_DATA <= volt_cfg;
          erlc_pkg::CMD_OFF_SEL:  RESP_DATA <= {4'h0, off_sel};
          erlc_pkg::CMD_OFF_VLIM: RESP_DATA <= off_vlim;
          erlc_pkg::CMD_OFF_ILIM: RESP_DATA <= off_ilim;
          erlc_pkg::CMD_ON_VLIM:  RESP_DATA <= on_vlim;
          erlc_pkg::CMD_ON_ILIM:  RESP_DATA <= on_ilim;
          erlc_pkg::CMD_WINDOW:   RESP_DATA <= window;
          erlc_pkg::CMD_OPTIONS:  RESP_DATA <= {5'h00, options};
          default:                RESP_DATA <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  property p_window;
    MEAS_VALID && (meas_diff > {8'h00, window}) |=> QUES_OUT_OF_TOL;
  endproperty
  a_window: assert property (p_window) else $error("tolerance flag missed");

  property p_off_zero;
    !OUTPUT_ON && (off_sel == 4'h0) |=> (VLIM_DAC == 8'h00) && (ILIM_DAC == 8'h00);
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("off limits not zero");

  property p_off_max;
    !OUTPUT_ON && off_sel[0] |=> VLIM_DAC == 8'hFF;
  endproperty
  a_off_max: assert property (p_off_max) else $error("voltage max not forced");

  property p_sec_clear;
    sec_clear |=> (off_sel == 4'h0) && (sv_options == 3'h0) && (window == 8'h20);
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("security clear incomplete");

  property p_linefeed;
    READ_EMPTY && options[0] |=> LF_SEND;
  endproperty
  a_linefeed: assert property (p_linefeed) else $error("empty read linefeed missed");

  property p_clear_only;
    dev_clear && !options[1] |=> STATUS_CLEAR && !RESET_LEVELS;
  endproperty
  a_clear_only: assert property (p_clear_only) else $error("status-only clear misbehaved");

  property p_reset_out;
    do_reset && !trip_off && !POWER_UP |=> RESET_LEVELS && (OUTPUT_ON == $past(options[2]));
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset output state wrong");

  property p_curr_trip;
    CURR_PROT_EVT && curr_cfg[6] && curr_cfg[2]
      |=> !OUTPUT_ON ##1 (!OUTPUT_ON || $past(out_on_cmd || do_reset));
  endproperty
  a_curr_trip: assert property (p_curr_trip) else $error("current trip kept output on");

  property p_err303;
    CURR_PROT_EVT && curr_cfg[6] && curr_cfg[3] |=> ERR_VALID && (ERR_CODE == 10'h12F);
  endproperty
  a_err303: assert property (p_err303) else $error("error 303 not raised");

  property p_ese_preset;
    do_reset && !POWER_UP && curr_cfg[4] && curr_cfg[5] |=> ESE_LOAD && (ESE_INIT == 8'h48);
  endproperty
  a_ese_preset: assert property (p_ese_preset) else $error("event enable preset wrong");

  property p_query;
    CMD_VALID && CMD_READ && (CMD_CODE == 4'h1) |=> RESP_VALID && (RESP_DATA == $past(volt_cfg));
  endproperty
  a_query: assert property (p_query) else $error("config query mismatch");
endmodule : erlc_core
`default_nettype wire

// ### erlc_host.sv
// Host model that issues one command at a time to the control block
`default_nettype none
module erlc_host (
  // Clock
  input  wire logic       clk,
  // Command port
  output var  logic       valid,
  output var  logic       rd,
  output var  logic [3:0] code,
  output var  logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle port from time zero
  initial begin
    valid = 1'h0;
    rd    = 1'h0;
    code  = 4'h0;
    data  = 8'h00;
  end
  // Held for one taking edge; data is inverted after, so stale bytes never look valid
  task automatic send(input logic r, input logic [3:0] c, input logic [7:0] d);
    @(posedge clk);
    valid <= 1'h1;
    rd    <= r;
    code  <= c;
    data  <= d;
    @(posedge clk);
    valid <= 1'h0;
    data  <= ~d;
    #1;
  endtask : send
endmodule : erlc_host
`default_nettype wire

// ### erlc_core_tb.sv
// Self-checking bench for the error-response and limit control block
`default_nettype none
module erlc_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'h0, rstn = 1'h0, cv, cr, rv, lf, sc, rl, q, on, sd, ev, cpe, el;
  logic [6:0] evs = 7'h00;
  logic       mc = 1'h0;
  logic [15:0] mm = 16'h0000, sm = 16'h1000;
  logic [3:0] cc;
  logic [7:0] cd, rd, vl, il, ei, a, b, s;
  logic [7:0] sels[7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h05, 8'h0A};
  logic [9:0] ec;
  int         n_fail = 0, n_tests = 0, seed = 61, cyc = 0;
  always #20 clk = ~clk;
  erlc_host HOST (.clk(clk), .valid(cv), .rd(cr), .code(cc), .data(cd));
  erlc_core DUT (.SYS_CLK(clk), .RSTN(rstn), .CMD_VALID(cv), .CMD_READ(cr), .CMD_CODE(cc),
    .CMD_DATA(cd), .RESP_VALID(rv), .RESP_DATA(rd), .POWER_UP(evs[0]), .READ_EMPTY(evs[1]),
    .LF_SEND(lf), .STATUS_CLEAR(sc), .RESET_LEVELS(rl), .MODE_CURRENT(mc),
    .MEAS_VALID(evs[2]), .MEAS_MAIN(mm), .SET_MAIN(sm), .CURR_PROT_EVT(evs[3]),
    .VOLT_PROT_EVT(evs[4]), .CURR_MEAS_ERR(evs[5]), .VOLT_MEAS_ERR(evs[6]),
    .QUES_OUT_OF_TOL(q), .OUTPUT_ON(on), .UNIT_SHUTDOWN(sd), .VLIM_DAC(vl), .ILIM_DAC(il),
    .ERR_VALID(ev), .ERR_CODE(ec), .CPE_EVENT(cpe), .ESE_LOAD(el), .ESE_INIT(ei));
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic summarize;
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic w(input logic [3:0] c, input logic [7:0] d);
    HOST.send(1'h0, c, d);
  endtask : w
  task automatic qry(input logic [3:0] c, input logic [7:0] e);
    HOST.send(1'h1, c, 8'h00);
    chk("query", {1'h0, rv, rd}, {2'h1, e});
  endtask : qry
  // One-cycle event pulse; result is read in the cycle after sampling
  task automatic pls(input int i);
    @(posedge clk);
    evs[i] <= 1'h1;
    @(posedge clk);
    evs <= 7'h00;
    #1;
  endtask : pls
  function automatic logic [7:0] lim(input logic mx, input logic us, input logic [7:0] v);
    return mx ? 8'hFF : (us ? v : 8'h00);
  endfunction : lim
  // Hang guard, far above the fewer than two hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    for (int c = 0; c < 3; c++) qry(c[3:0], 8'h00);
    repeat (4) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      w(erlc_pkg::CMD_CURR_CFG, a);
      w(erlc_pkg::CMD_VOLT_CFG, b);
      qry(erlc_pkg::CMD_CURR_CFG, a);
      qry(erlc_pkg::CMD_VOLT_CFG, b);
    end
    // Saved copy survives a power cycle, the unsaved edit does not
    w(erlc_pkg::CMD_SAVE_SHUT, 8'h00);
    w(erlc_pkg::CMD_CURR_CFG, ~a);
    pls(0);
    qry(erlc_pkg::CMD_CURR_CFG, a);
    w(erlc_pkg::CMD_CURR_CFG, 8'h00);
    w(erlc_pkg::CMD_VOLT_CFG, 8'h00);
    a = 8'($random(seed));
    b = 8'($random(seed));
    w(erlc_pkg::CMD_OFF_VLIM, a);
    w(erlc_pkg::CMD_OFF_ILIM, b);
    foreach (sels[i]) begin
      s = sels[i];
      w(erlc_pkg::CMD_OFF_SEL, s);
      @(posedge clk);
      #1;
      chk("vlim", vl, lim(s[0], s[2], a));
      chk("ilim", il, lim(s[1], s[3], b));
    end
    w(erlc_pkg::CMD_OPTIONS, 8'h07);
    w(erlc_pkg::CMD_SEC_CLEAR, 8'h00);
    qry(erlc_pkg::CMD_OFF_SEL, 8'h00);
    qry(erlc_pkg::CMD_OPTIONS, 8'h00);
    w(erlc_pkg::CMD_CURR_CFG, 8'h80);
    w(erlc_pkg::CMD_ON_ILIM, a);
    w(erlc_pkg::CMD_OUT_ON, 8'h00);
    @(posedge clk);
    #1;
    chk("ilim_on", il, a);
    chk("vlim_on", vl, 8'hFF);
    w(erlc_pkg::CMD_CURR_CFG, 8'h70);
    w(erlc_pkg::CMD_OPTIONS, 8'h04);
    w(erlc_pkg::CMD_RESET, 8'h00);
    chk("rst_on", {on, rl, el}, 3'h7);
    chk("ese", ei, 8'h48);
    w(erlc_pkg::CMD_CURR_CFG, 8'h50);
    w(erlc_pkg::CMD_OPTIONS, 8'h00);
    w(erlc_pkg::CMD_RESET, 8'h00);
    chk("rst_off", {on, rl}, 2'h1);
    chk("ese", ei, 8'h08);
    for (int d = 0; d < 2; d++) begin
      w(erlc_pkg::CMD_OPTIONS, d ? 8'h02 : 8'h00);
      w(erlc_pkg::CMD_OUT_ON, 8'h00);
      w(erlc_pkg::CMD_DEV_CLEAR, 8'h00);
      chk("dclr", {on, sc, rl}, d ? 3'h3 : 3'h6);
    end
    // Protection trips: error code and forced output off
    w(erlc_pkg::CMD_CURR_CFG, 8'h4C);
    w(erlc_pkg::CMD_OUT_ON, 8'h00);
    pls(3);
    chk("cprot", {on, ev, ec}, {2'h1, 10'h12F});
    w(erlc_pkg::CMD_CURR_CFG, 8'h00);
    w(erlc_pkg::CMD_VOLT_CFG, 8'h4C);
    w(erlc_pkg::CMD_OUT_ON, 8'h00);
    pls(4);
    chk("vprot", {on, ev, ec}, {2'h1, 10'h130});
    mm <= sm + 16'h0028;
    pls(2);
    chk("tol", q, 1'h1);
    mm <= sm + 16'h0005;
    pls(2);
    chk("tol", q, 1'h0);
    w(erlc_pkg::CMD_OPTIONS, 8'h01);
    pls(1);
    chk("lf", lf, 1'h1);
    // Measurement errors: device message, forced off, sticky shutdown
    w(erlc_pkg::CMD_VOLT_CFG, 8'h03);
    w(erlc_pkg::CMD_OUT_ON, 8'h00);
    pls(6);
    chk("vmeas", {on, ev, ec}, {2'h1, 10'h12C});
    w(erlc_pkg::CMD_VOLT_CFG, 8'h00);
    w(erlc_pkg::CMD_CURR_CFG, 8'h63);
    pls(3);
    chk("cpe", {cpe, ev}, 2'h2);
    w(erlc_pkg::CMD_OUT_ON, 8'h00);
    mc <= 1'h1;
    pls(5);
    chk("cmeas", {on, sd, ev, ec}, {3'h3, 10'h12C});
    w(erlc_pkg::CMD_OUT_ON, 8'h00);
    chk("refuse", on, 1'h0);
    pls(0);
    chk("sd_clr", sd, 1'h0);
    summarize();
  end
endmodule : erlc_core_tb
`default_nettype wire
